// ### hw/rocof_stage_ctl.v
// rocof stage block top: eight stages, events, records, bus slave
`timescale 1ns/1ps
`default_nettype none
`include "rocof_regs.vh"
// Summary of operation
// RULE1 - sample blocking input every program cycle
// RULE2 - blocking only from dedicated matrix input; code also blocks every stage in modes blocked and test/blocked
// RULE3 - pick-up without block: start, time delay
// RULE4 - pick-up with block: blocked, no timing
// RULE5 - block during start: drop start, release
// RULE6 - block gives display note, startup values
// RULE7 - source blocks 5 ms before delay ends
// RULE8 - on and off events per stage status
// RULE9 - forward on, off or both by selection
// RULE10 - events carry time stamp and data
// RULE11 - keep twelve newest records, drop oldest
// RULE12 - record time, event, pre, fault, group
// RULE13 - condition: normal, start, trip, blocked
// RULE14 - node operating mode code one to five
// RULE15 - measured rocof_stage in mHz/s
// RULE16 - ratio to pick-up in 0.005 steps
// RULE17 - expected operating time in 5 ms
// RULE18 - signed remaining time in 5 ms
// RULE19 - instant start and trip share stamp
// RULE20 - time stamps count milliseconds
// RULE21 - release with 100 mHz/s hysteresis
// RULE22 - each stage keeps independent state
module rocof_stage_ctl #(
   parameter MS_CYCLES = `ROCOF_CLK_HZ / 1000 * `ROCOF_TS_MS,
   parameter REC_N     = `ROCOF_REC_DEPTH
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire [15:0] meas_dfdt_i,
   input  wire [15:0] meas_freq_i,
   input  wire [7:0]  blk_i,
   output wire [7:0]  start_o,
   output wire [7:0]  trip_o,
   output wire [7:0]  blocked_o,
   output reg         hmi_note_o,
   output reg         ev_valid_o,
   input  wire        ev_ready_i,
   output reg  [2:0]  ev_stage_o,
   output reg  [1:0]  ev_kind_o,
   output reg         ev_on_o,
   output reg  [31:0] ev_time_o,
   output reg  [15:0] ev_dfdt_o,
   output reg  [15:0] ev_freq_o
);
   localparam PRE_N = `ROCOF_PRE_MS / `ROCOF_PCYC_MS;
   localparam [4:0] RN5 = REC_N;

   // ---------------------------------------------------------------
   // time base
   // ---------------------------------------------------------------
   wire ms_tick;
   wire cyc_en;
   reg  [31:0] ms_reg;

   rocof_tick #(.DIV(MS_CYCLES), .W(16)) u_ms_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (1'b1),
      .tick_o (ms_tick)
   );

   rocof_tick #(.DIV(`ROCOF_PCYC_MS), .W(4)) u_pcyc_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (ms_tick),
      .tick_o (cyc_en)
   );

   // free millisecond stamp counter
   always @(posedge clk_i) begin
      if (rst_i)
         ms_reg <= 32'h00000000;
      else if (ms_tick)
         ms_reg <= ms_reg + 32'h00000001; // RULE20
   end

   // ---------------------------------------------------------------
   // registers written by software
   // ---------------------------------------------------------------
   reg  [31:0] ctrl_reg;
   reg  [5:0]  evsel_reg;
   reg  [2:0]  ssel_reg;
   reg  [3:0]  rsel_reg;
   reg  [15:0] pick_reg [0:7];
   reg  [19:0] dly_reg  [0:7];
   wire [7:0]  en_bits = ctrl_reg[7:0];
   wire [3:0]  sg_code = ctrl_reg[11:8];
   wire [2:0]  mode    = ctrl_reg[14:12];
   wire mode_blk = (mode == `ROCOF_MODE_BLK) || (mode == `ROCOF_MODE_TBLK);
   wire mode_off = (mode == `ROCOF_MODE_OFF);

   // magnitude of the measured rate, mHz/s
   wire [15:0] mag = meas_dfdt_i[15] ? (~meas_dfdt_i + 16'h0001)
                                     : meas_dfdt_i;

   // ---------------------------------------------------------------
   // stages
   // ---------------------------------------------------------------
   wire [15:0] su_df_w  [0:7];
   wire [15:0] su_f_w   [0:7];
   wire [20:0] rem_w    [0:7];

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : stg
         rocof_stage_unit #(.DW(16), .TW(20)) u_stage (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .cyc_en_i  (cyc_en),
            .en_i      (en_bits[g] & ~mode_off),
            .blk_i     (blk_i[g] | mode_blk), // RULE2
            .mag_i     (mag),
            .pickup_i  (pick_reg[g]),
            .delay_i   (dly_reg[g]),
            .dfdt_i    (meas_dfdt_i),
            .freq_i    (meas_freq_i),
            .start_o   (start_o[g]), // RULE22
            .trip_o    (trip_o[g]),
            .blocked_o (blocked_o[g]),
            .remain_o  (rem_w[g]),
            .su_dfdt_o (su_df_w[g]),
            .su_freq_o (su_f_w[g])
         );
      end
   endgenerate

   // condition code of one stage
   function [1:0] cond;
      input s, t, b;
      begin
         if (b)
            cond = `ROCOF_COND_BLOCKED; // RULE13
         else if (t)
            cond = `ROCOF_COND_TRIP;
         else if (s)
            cond = `ROCOF_COND_START;
         else
            cond = `ROCOF_COND_NORMAL;
      end
   endfunction

   // ---------------------------------------------------------------
   // pre-fault history, one entry per program cycle
   // ---------------------------------------------------------------
   reg [15:0] hist_df [0:PRE_N-1];
   reg [15:0] hist_f  [0:PRE_N-1];
   integer h;

   always @(posedge clk_i) begin
      if (rst_i) begin
         for (h = 0; h < PRE_N; h = h + 1) begin
            hist_df[h] <= 16'h0000;
            hist_f[h]  <= 16'h0000;
         end
      end else if (cyc_en) begin
         hist_df[0] <= meas_dfdt_i;
         hist_f[0]  <= meas_freq_i;
         for (h = 1; h < PRE_N; h = h + 1) begin
            hist_df[h] <= hist_df[h-1];
            hist_f[h]  <= hist_f[h-1];
         end
      end
   end

   // ---------------------------------------------------------------
   // event detection and drain
   // ---------------------------------------------------------------
   wire [23:0] cur_w = {blocked_o, trip_o, start_o};
   wire [23:0] chg_w;
   reg  [23:0] prev_reg;
   reg  [23:0] pend_reg;
   reg  [31:0] snap_t_reg;
   reg  [15:0] snap_df_reg;
   reg  [15:0] snap_f_reg;
   reg  [15:0] snap_pdf_reg;
   reg  [15:0] snap_pf_reg;
   reg  [4:0]  sel_idx;
   reg         sel_hit;
   integer     k;

   assign chg_w = cur_w ^ prev_reg; // RULE8

   // lowest pending event first
   always @* begin
      sel_idx = 5'h00;
      sel_hit = 1'b0;
      for (k = 23; k >= 0; k = k - 1) begin
         if (pend_reg[k]) begin
            sel_idx = k[4:0];
            sel_hit = 1'b1;
         end
      end
   end

   wire        busy = ev_valid_o & ~ev_ready_i;
   wire        take = sel_hit & ~busy;
   wire [1:0]  kind = sel_idx[4:3];
   wire [2:0]  stn  = sel_idx[2:0];
   wire        lvl  = cur_w[sel_idx];
   wire        want = lvl ? evsel_reg[{kind, 1'b0}]  // RULE9
                          : evsel_reg[{kind, 1'b1}];
   wire        is_blk = (kind == `ROCOF_KIND_BLOCK);
   wire [23:0] clr_w = take ? (24'h000001 << sel_idx) : 24'h000000;
   wire        rec_we = take & lvl & ~is_blk;

   // snapshot once per change set, so joint start and trip match
   always @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg     <= 24'h000000;
         pend_reg     <= 24'h000000;
         snap_t_reg   <= 32'h00000000;
         snap_df_reg  <= 16'h0000;
         snap_f_reg   <= 16'h0000;
         snap_pdf_reg <= 16'h0000;
         snap_pf_reg  <= 16'h0000;
      end else begin
         prev_reg <= cur_w;
         pend_reg <= (pend_reg & ~clr_w) | chg_w; // set beats clear
         if (|chg_w) begin
            snap_t_reg   <= ms_reg; // RULE19
            snap_df_reg  <= meas_dfdt_i;
            snap_f_reg   <= meas_freq_i;
            snap_pdf_reg <= hist_df[PRE_N-1];
            snap_pf_reg  <= hist_f[PRE_N-1];
         end
      end
   end

   // event port, held until the buffer takes it
   always @(posedge clk_i) begin
      if (rst_i) begin
         ev_valid_o <= 1'b0;
         ev_stage_o <= 3'h0;
         ev_kind_o  <= 2'h0;
         ev_on_o    <= 1'b0;
         ev_time_o  <= 32'h00000000;
         ev_dfdt_o  <= 16'h0000;
         ev_freq_o  <= 16'h0000;
         hmi_note_o <= 1'b0;
      end else begin
         hmi_note_o <= take & lvl & is_blk; // RULE6
         if (ev_valid_o & ev_ready_i)
            ev_valid_o <= 1'b0;
         if (take & want) begin
            ev_valid_o <= 1'b1;
            ev_stage_o <= stn;
            ev_kind_o  <= kind;
            ev_on_o    <= lvl;
            ev_time_o  <= snap_t_reg; // RULE10
            ev_dfdt_o  <= is_blk ? su_df_w[stn] : snap_df_reg;
            ev_freq_o  <= is_blk ? su_f_w[stn]  : snap_f_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // record ring of the newest operations
   // ---------------------------------------------------------------
   reg [31:0] rec_t   [0:REC_N-1];
   reg [15:0] rec_inf [0:REC_N-1];
   reg [31:0] rec_pre [0:REC_N-1];
   reg [31:0] rec_flt [0:REC_N-1];
   reg [3:0]  wptr_reg;
   reg [3:0]  rcnt_reg;

   // overwriting the oldest slot discards it
   always @(posedge clk_i) begin
      if (rst_i) begin
         wptr_reg <= 4'h0;
         rcnt_reg <= 4'h0;
      end else if (rec_we) begin
         rec_t[wptr_reg]   <= snap_t_reg; // RULE12
         rec_inf[wptr_reg] <= {4'h0, sg_code, 3'h0, kind, stn};
         rec_pre[wptr_reg] <= {snap_pf_reg, snap_pdf_reg};
         rec_flt[wptr_reg] <= {snap_f_reg, snap_df_reg};
         if ({1'b0, wptr_reg} == RN5 - 5'h01)
            wptr_reg <= 4'h0; // RULE11
         else
            wptr_reg <= wptr_reg + 4'h1;
         if ({1'b0, rcnt_reg} != RN5)
            rcnt_reg <= rcnt_reg + 4'h1;
      end
   end

   // index 0 of the read select is the newest record
   wire [4:0] rd_raw = {1'b0, wptr_reg} + RN5 - 5'h01 - {1'b0, rsel_reg};
   wire [4:0] rd_w5  = (rd_raw >= RN5) ? (rd_raw - RN5) : rd_raw;
   wire [3:0] rd_idx = rd_w5[3:0];
   wire       rd_ok  = ({1'b0, rsel_reg} < RN5) &&
                       ({1'b0, rsel_reg} < {1'b0, rcnt_reg});

   // ---------------------------------------------------------------
   // live values of the selected stage
   // ---------------------------------------------------------------
   reg  [15:0] ratio_reg;
   wire [23:0] ratio_num = {8'h00, mag} * `ROCOF_RATIO_STEPS;
   wire [23:0] ratio_q   = ratio_num / {8'h00, pick_reg[ssel_reg]};
   wire [15:0] cond_all;

   genvar c;
   generate
      for (c = 0; c < 8; c = c + 1) begin : cnd
         assign cond_all[2*c+1:2*c] = cond(start_o[c], trip_o[c],
                                           blocked_o[c]);
      end
   endgenerate

   // divider result registered, a zero setting reads zero
   always @(posedge clk_i) begin
      if (rst_i)
         ratio_reg <= 16'h0000;
      else if (pick_reg[ssel_reg] == 16'h0000)
         ratio_reg <= 16'h0000;
      else
         ratio_reg <= ratio_q[15:0]; // RULE16
   end

   // ---------------------------------------------------------------
   // wishbone slave, one wait state, ack for every address
   // ---------------------------------------------------------------
   wire        wb_req = wb_cyc_i & wb_stb_i;
   wire        wr_en  = wb_req & wb_we_i & ~wb_ack_o;
   wire [31:0] bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] old_w  = (wb_adr_i == `ROCOF_ADR_CTRL)   ? ctrl_reg :
                        (wb_adr_i == `ROCOF_ADR_EVSEL)  ? {26'h0, evsel_reg} :
                        (wb_adr_i == `ROCOF_ADR_SSEL)   ? {29'h0, ssel_reg} :
                        (wb_adr_i == `ROCOF_ADR_PICKUP) ?
                           {16'h0, pick_reg[ssel_reg]} :
                        (wb_adr_i == `ROCOF_ADR_DELAY)  ?
                           {12'h0, dly_reg[ssel_reg]} :
                        {28'h0, rsel_reg};
   wire [31:0] new_w  = (old_w & ~bmask) | (wb_dat_i & bmask);
   wire [20:0] rem_sel = rem_w[ssel_reg];
   integer r;

   // software-written registers, byte lanes honoured
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg  <= `ROCOF_CTRL_RST;
         evsel_reg <= `ROCOF_EVSEL_RST;
         ssel_reg  <= 3'h0;
         rsel_reg  <= 4'h0;
         for (r = 0; r < 8; r = r + 1) begin
            pick_reg[r] <= `ROCOF_PICKUP_RST;
            dly_reg[r]  <= `ROCOF_DELAY_RST;
         end
      end else if (wr_en) begin
         case (wb_adr_i)
            `ROCOF_ADR_CTRL:   ctrl_reg  <= {17'h0, new_w[14:0]};
            `ROCOF_ADR_EVSEL:  evsel_reg <= new_w[5:0];
            `ROCOF_ADR_SSEL:   ssel_reg  <= new_w[2:0];
            `ROCOF_ADR_PICKUP: pick_reg[ssel_reg] <= new_w[15:0];
            `ROCOF_ADR_DELAY:  dly_reg[ssel_reg]  <= new_w[19:0];
            `ROCOF_ADR_RSEL:   rsel_reg  <= new_w[3:0];
            default:           rsel_reg  <= rsel_reg;
         endcase
      end
   end

   // read data and ack, ack drops the cycle after it is given
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         case (wb_adr_i)
            `ROCOF_ADR_CTRL:    wb_dat_o <= ctrl_reg;
            `ROCOF_ADR_EVSEL:   wb_dat_o <= {26'h0, evsel_reg};
            `ROCOF_ADR_SSEL:    wb_dat_o <= {29'h0, ssel_reg};
            `ROCOF_ADR_PICKUP:  wb_dat_o <= {16'h0, pick_reg[ssel_reg]};
            `ROCOF_ADR_DELAY:   wb_dat_o <= {12'h0, dly_reg[ssel_reg]}; // RULE17
            `ROCOF_ADR_STAT:    wb_dat_o <= {13'h0, mode, 11'h0, // RULE14
                                  blocked_o[ssel_reg], trip_o[ssel_reg],
                                  start_o[ssel_reg], cond_all[2*ssel_reg+:2]};
            `ROCOF_ADR_REMAIN:  wb_dat_o <= {{11{rem_sel[20]}}, rem_sel}; // RULE18
            `ROCOF_ADR_RATIO:   wb_dat_o <= {16'h0, ratio_reg};
            `ROCOF_ADR_MEAS:    wb_dat_o <= {16'h0, mag}; // RULE15
            `ROCOF_ADR_CONDALL: wb_dat_o <= {16'h0, cond_all};
            `ROCOF_ADR_RSEL:    wb_dat_o <= {28'h0, rsel_reg};
            `ROCOF_ADR_RTIME:   wb_dat_o <= rd_ok ? rec_t[rd_idx] : 32'h0;
            `ROCOF_ADR_RINFO:   wb_dat_o <= {rcnt_reg, 12'h0,
                                  rd_ok ? rec_inf[rd_idx] : 16'h0};
            `ROCOF_ADR_RPRE:    wb_dat_o <= rd_ok ? rec_pre[rd_idx] : 32'h0;
            `ROCOF_ADR_RFLT:    wb_dat_o <= rd_ok ? rec_flt[rd_idx] : 32'h0;
            `ROCOF_ADR_TIME:    wb_dat_o <= ms_reg;
            default:            wb_dat_o <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### hw/rocof_regs.vh
// constants, codes and register offsets of the rocof stage block
`ifndef ROCOF_REGS_VH
`define ROCOF_REGS_VH
// ---------------------------------------------------------------
// time base
// ---------------------------------------------------------------
`define ROCOF_CLK_HZ      20000000
`define ROCOF_TS_MS       1
`define ROCOF_PCYC_MS     5
`define ROCOF_PRE_MS      20
`define ROCOF_HYST_MHZ    16'h0064
`define ROCOF_RATIO_STEPS 24'h0000C8
`define ROCOF_REC_DEPTH   12
// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define ROCOF_COND_NORMAL  2'h0
`define ROCOF_COND_START   2'h1
`define ROCOF_COND_TRIP    2'h2
`define ROCOF_COND_BLOCKED 2'h3
`define ROCOF_MODE_ON      3'h1
`define ROCOF_MODE_BLK     3'h2
`define ROCOF_MODE_TEST    3'h3
`define ROCOF_MODE_TBLK    3'h4
`define ROCOF_MODE_OFF     3'h5
`define ROCOF_KIND_START   2'h0
`define ROCOF_KIND_TRIP    2'h1
`define ROCOF_KIND_BLOCK   2'h2
// ---------------------------------------------------------------
// register offsets and reset values
// ---------------------------------------------------------------
`define ROCOF_ADR_CTRL    8'h00
`define ROCOF_ADR_EVSEL   8'h04
`define ROCOF_ADR_SSEL    8'h08
`define ROCOF_ADR_PICKUP  8'h0C
`define ROCOF_ADR_DELAY   8'h10
`define ROCOF_ADR_STAT    8'h14
`define ROCOF_ADR_REMAIN  8'h18
`define ROCOF_ADR_RATIO   8'h1C
`define ROCOF_ADR_MEAS    8'h20
`define ROCOF_ADR_CONDALL 8'h24
`define ROCOF_ADR_RSEL    8'h28
`define ROCOF_ADR_RTIME   8'h2C
`define ROCOF_ADR_RINFO   8'h30
`define ROCOF_ADR_RPRE    8'h34
`define ROCOF_ADR_RFLT    8'h38
`define ROCOF_ADR_TIME    8'h3C
`define ROCOF_CTRL_RST    32'h00001100
`define ROCOF_EVSEL_RST   6'h3F
`define ROCOF_PICKUP_RST  16'h00C8
`define ROCOF_DELAY_RST   20'h00014
`endif

// ### hw/rocof_tick.v
// enable-pulse divider used for the millisecond and program-cycle rates
`timescale 1ns/1ps
`default_nettype none
module rocof_tick #(
   parameter DIV = 20000,
   parameter W   = 16
) (
   input  wire clk_i,
   input  wire rst_i,
   input  wire en_i,
   output reg  tick_o
);
   localparam [W-1:0] LAST = DIV - 1;
   reg [W-1:0] cnt_reg;

   // one pulse every DIV enabled cycles
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o  <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (en_i) begin
            if (cnt_reg == LAST) begin
               cnt_reg <= {W{1'b0}};
               tick_o  <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### hw/rocof_stage_unit.v
// one protection stage: pick-up with hysteresis, blocking, timer
`timescale 1ns/1ps
`default_nettype none
`include "rocof_regs.vh"
module rocof_stage_unit #(
   parameter DW = 16,
   parameter TW = 20
) (
   input  wire                 clk_i,
   input  wire                 rst_i,
   input  wire                 cyc_en_i,
   input  wire                 en_i,
   input  wire                 blk_i,
   input  wire [DW-1:0]        mag_i,
   input  wire [DW-1:0]        pickup_i,
   input  wire [TW-1:0]        delay_i,
   input  wire [DW-1:0]        dfdt_i,
   input  wire [DW-1:0]        freq_i,
   output reg                  start_o,
   output reg                  trip_o,
   output reg                  blocked_o,
   output wire signed [TW:0]   remain_o,
   output reg  [DW-1:0]        su_dfdt_o,
   output reg  [DW-1:0]        su_freq_o
);
   reg           pick_reg;
   reg  [TW-1:0] elap_reg;
   wire [DW:0]   hyst_sum = {1'b0, mag_i} + {1'b0, `ROCOF_HYST_MHZ};
   wire [TW-1:0] elap_inc = elap_reg + 1'b1;
   // held pick-up drops only 100 mHz/s below the setting
   wire pick_now = pick_reg ? (hyst_sum >= {1'b0, pickup_i}) // RULE21
                            : (mag_i >= pickup_i);

   // delay counts in 5 ms steps, one per program cycle
   assign remain_o = $signed({1'b0, delay_i}) - $signed({1'b0, elap_reg});

   // state moves only on the program-cycle strobe
   always @(posedge clk_i) begin
      if (rst_i) begin
         pick_reg  <= 1'b0;
         elap_reg  <= {TW{1'b0}};
         start_o   <= 1'b0;
         trip_o    <= 1'b0;
         blocked_o <= 1'b0;
         su_dfdt_o <= {DW{1'b0}};
         su_freq_o <= {DW{1'b0}};
      end else if (cyc_en_i) begin
         if (!en_i) begin
            pick_reg  <= 1'b0;
            elap_reg  <= {TW{1'b0}};
            start_o   <= 1'b0;
            trip_o    <= 1'b0;
            blocked_o <= 1'b0;
         end else begin
            pick_reg <= pick_now;
            // startup values kept for the blocking event
            if (pick_now && !pick_reg) begin
               su_dfdt_o <= dfdt_i; // RULE6
               su_freq_o <= freq_i;
            end
            // block is looked at before the pick-up result
            if (pick_now && blk_i) begin // RULE1
               start_o   <= 1'b0; // RULE4
               trip_o    <= 1'b0; // RULE5
               blocked_o <= 1'b1;
               elap_reg  <= {TW{1'b0}};
            end else if (pick_now) begin
               start_o   <= 1'b1; // RULE3
               blocked_o <= 1'b0;
               if (!trip_o)
                  elap_reg <= elap_inc;
               if (elap_inc >= delay_i)
                  trip_o <= 1'b1;
            end else begin
               // definite time: release is immediate
               start_o   <= 1'b0;
               trip_o    <= 1'b0;
               blocked_o <= 1'b0;
               elap_reg  <= {TW{1'b0}};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/rocof_chk.sv
// assertion checker bound to the rocof stage block top
`timescale 1ns/1ps
`default_nettype none
module rocof_chk #(
   parameter MS_CYCLES = 4
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [7:0]  blk_i,
   input wire logic [7:0]  start_o,
   input wire logic [7:0]  trip_o,
   input wire logic [7:0]  blocked_o,
   input wire logic        hmi_note_o,
   input wire logic        ev_valid_o,
   input wire logic        ev_ready_i,
   input wire logic [1:0]  ev_kind_o,
   input wire logic        ev_on_o,
   input wire logic [31:0] ev_time_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] bs_cnt;
   // cycles a stage stays started while blocked; must end by a strobe
   always_ff @(posedge clk_i) begin
      if (rst_i || !(|(blk_i & start_o))) bs_cnt <= 32'h0;
      else bs_cnt <= bs_cnt + 32'h1;
   end
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   ev_hold_a: assert property (ev_valid_o && !ev_ready_i |=> ev_valid_o
      && $stable(ev_time_o) && $stable({ev_kind_o, ev_on_o}))
      else $error("event changed before taken");
   blk_nostart_a: assert property (|(start_o & ~$past(start_o)) |->
      !(|(start_o & ~$past(start_o) & $past(blk_i))))
      else $error("start rose while blocked");
   trip_start_a: assert property (!(|(trip_o & ~$past(trip_o) & ~start_o)))
      else $error("trip without start");
   start_excl_a: assert property ((start_o & blocked_o) == 8'h00)
      else $error("start and blocked together");
   blk_clear_a: assert property (bs_cnt <= 10 * MS_CYCLES + 4)
      else $error("start held under block");
   // the note comes with the drain of a block on event, wanted or not
   hmi_note_a: assert property (hmi_note_o |-> $past(|blocked_o) &&
      (!ev_valid_o || (ev_on_o && ev_kind_o == 2'h2)))
      else $error("display note mismatch");
   note_load_a: assert property (ev_valid_o && ev_on_o && ev_kind_o == 2'h2
      && $past(!ev_valid_o || ev_ready_i) |-> hmi_note_o)
      else $error("block event without note");
   cover property ($rose(|trip_o));
   cover property ($rose(|blocked_o));
   cover property (hmi_note_o);
endmodule
bind rocof_stage_ctl rocof_chk #(.MS_CYCLES(MS_CYCLES)) rocof_chk_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .blk_i(blk_i), .start_o(start_o), .trip_o(trip_o),
   .blocked_o(blocked_o), .hmi_note_o(hmi_note_o), .ev_valid_o(ev_valid_o),
   .ev_ready_i(ev_ready_i), .ev_kind_o(ev_kind_o), .ev_on_o(ev_on_o),
   .ev_time_o(ev_time_o));
`default_nettype wire

// ### verif/rocof_ev_sink.sv
// event buffer model: prompt or slow acceptance, counts on and off
`timescale 1ns/1ps
`default_nettype none
module rocof_ev_sink (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   input  wire logic ev_valid_i,
   input  wire logic ev_on_i,
   output var  logic ev_ready_o,
   output var  int   on_n,
   output var  int   off_n
);
   logic [1:0] ph;
   // slow mode stalls three cycles in four
   always_ff @(posedge clk_i) begin
      ph <= rst_i ? 2'h0 : ph + 2'h1;
      ev_ready_o <= !rst_i && (!slow_i || ph == 2'h3);
      if (rst_i) on_n <= 0;
      else if (ev_valid_i && ev_ready_o && ev_on_i) on_n <= on_n + 1;
      if (rst_i) off_n <= 0;
      else if (ev_valid_i && ev_ready_o && !ev_on_i) off_n <= off_n + 1;
   end
endmodule
`default_nettype wire

// ### verif/rocof_stage_blocking_events_bench.sv
// self-checking bench of the rocof stage block
`timescale 1ns/1ps
`default_nettype none
`include "rocof_regs.vh"
module rocof_stage_blocking_events_bench;
   logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, slow = 1;
   logic [7:0]  adr = 0, blk = 0, st, tr, bl;
   logic [31:0] dat = 0, rdat, rd_q, seed = 32'h3665;
   logic [15:0] dfdt = 0, m;
   logic        ack, note, vld, rdy, on;
   logic [1:0]  kind;
   int          mismatches = 0, checks = 0, on_n, off_n;
   rocof_stage_ctl #(.MS_CYCLES(4)) rocof_stage_ctl_inst (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .meas_dfdt_i(dfdt), .meas_freq_i(16'h1388),
      .blk_i(blk), .start_o(st), .trip_o(tr), .blocked_o(bl),
      .hmi_note_o(note), .ev_valid_o(vld), .ev_ready_i(rdy),
      .ev_stage_o(), .ev_kind_o(kind), .ev_on_o(on), .ev_time_o(),
      .ev_dfdt_o(), .ev_freq_o());
   rocof_ev_sink rocof_ev_sink_inst (.clk_i(clk_i), .rst_i(rst_i),
      .slow_i(slow), .ev_valid_i(vld), .ev_on_i(on), .ev_ready_o(rdy),
      .on_n(on_n), .off_n(off_n));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // condition codes: tripped 2, blocked 3, otherwise started 1
   function automatic logic [31:0] exp_all(input logic [7:0] t, b);
      exp_all = 32'h0;
      for (int i = 0; i < 8; i++) exp_all[2*i +: 2] = t[i] ? 2'h2 : b[i] ?
         2'h3 : 2'h1;
   endfunction
   task automatic cmp(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // one classic cycle, request held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
      if (ack !== 1'b1) mismatches++;
      // read data taken at the edge that sees ack
      rd_q = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(rd_q, e);
   endtask
   task automatic pc(input int n);
      repeat (n * 20) @(posedge clk_i);
   endtask
   task automatic close_out();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_rd(`ROCOF_ADR_CTRL, `ROCOF_CTRL_RST);
      chk_rd(`ROCOF_ADR_EVSEL, 32'h3F);
      chk_rd(8'hF0, 32'h0);
      bus(1'b1, `ROCOF_ADR_CTRL, 32'h000011FF);
      bus(1'b1, `ROCOF_ADR_DELAY, 32'h2);
      seed = xs(seed);
      m = 16'h012C + seed[7:0];
      blk <= 8'h02;
      dfdt <= m;
      pc(5);
      cmp({st, tr, bl}, {8'hFD, 8'h01, 8'h02});
      chk_rd(`ROCOF_ADR_CONDALL, exp_all(8'h01, 8'h02));
      chk_rd(`ROCOF_ADR_STAT, 32'h0001000E);
      chk_rd(`ROCOF_ADR_MEAS, {16'h0, m});
      chk_rd(`ROCOF_ADR_RATIO, {16'h0, m});
      chk_rd(`ROCOF_ADR_DELAY, 32'h2);
      chk_rd(`ROCOF_ADR_RINFO, 32'h80000108);
      blk <= 8'h06;
      pc(3);
      cmp(st, 8'hF9);
      cmp({on_n[7:0], off_n[7:0]}, 16'h0A01);
      bus(1'b1, `ROCOF_ADR_EVSEL, 32'h15);
      slow <= 1'b0;
      dfdt <= 16'h0096;
      pc(3);
      cmp(st, 8'hF9);
      blk <= 8'h00;
      dfdt <= 16'h0032;
      pc(3);
      cmp({st, tr}, 16'h0);
      cmp({on_n[7:0], off_n[7:0]}, 16'h0A01);
      // two more pick-up rounds overfill the record ring
      repeat (2) begin
         dfdt <= m;
         pc(2);
         dfdt <= 16'h0000;
         pc(2);
      end
      chk_rd(`ROCOF_ADR_RINFO, 32'hC0000108);
      // mode off clears every stage, mode blocked blocks all
      bus(1'b1, `ROCOF_ADR_CTRL, 32'h000051FF);
      dfdt <= m;
      pc(2);
      cmp({st, tr, bl}, 32'h0);
      bus(1'b1, `ROCOF_ADR_CTRL, 32'h000021FF);
      pc(2);
      cmp({st, bl}, 16'h00FF);
      close_out();
   end
endmodule
`default_nettype wire
